// File: verilog/agsc_pkg.sv
`default_nettype none
package agsc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 125;
    localparam int unsigned SETTLE_US = 10;
    localparam logic [10:0] SETTLE_CYC = 11'(SETTLE_US * CLK_MHZ);
    localparam int unsigned MODEM_BAUD = 9600;
    localparam int unsigned BIT_CYCLES_DEF = (CLK_MHZ * 1000000) / MODEM_BAUD;

    // ----------------------------------------------------------------
    // attenuator and alarm figures
    // ----------------------------------------------------------------
    localparam logic [4:0] ATTN_MAX = 5'h1e;
    localparam logic [4:0] ATTN_STEP = 5'h01;
    localparam logic [4:0] ATTN_MIN = 5'h00;
    localparam int unsigned N_ALARM = 4;
    localparam logic [3:0] ALARM_RST = 4'h0;
    localparam logic [4:0] PEND_RST = 5'h00;

    // ----------------------------------------------------------------
    // modem message codes and frame
    // ----------------------------------------------------------------
    localparam logic [7:0] MSG_ALARM = 8'h80;
    localparam logic [7:0] MSG_DONE = 8'h40;
    localparam logic [3:0] FRAME_BITS = 4'ha;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_MAX = 4'h1,
        ST_SETTLE = 4'h2,
        ST_DONE = 4'h4,
        ST_TRACK = 4'h8
    } agsc_state_type;

    typedef struct packed {
        logic valid;
        logic [5:0] dbm;
    } agsc_meas_type;

    typedef struct packed {
        logic ul_wr;
        logic dl_wr;
        logic [4:0] value;
    } agsc_man_type;

endpackage
`default_nettype wire

// File: verilog/agsc_modem_tx.sv
`timescale 1ns/100ps
`default_nettype none
module agsc_modem_tx #(
    parameter int unsigned BIT_CYCLES = agsc_pkg::BIT_CYCLES_DEF
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic start_i,
    input wire logic [7:0] byte_i,
    output logic busy_o,
    output logic txd_o
);

    logic [9:0] shift;
    logic [9:0] next_shift;
    logic [3:0] bits;
    logic [3:0] next_bits;
    logic [15:0] timer;
    logic [15:0] next_timer;
    logic busy;
    logic next_busy;

    // ----------------------------------------------------------------
    // 8n1 framing, lsb first
    // ----------------------------------------------------------------
    always_comb
    begin
        next_shift = shift;
        next_bits = bits;
        next_timer = timer;
        next_busy = busy;
        if (!busy && start_i)
        begin
            // start bit low, stop bit high
            next_shift = {1'b1, byte_i, 1'b0};
            next_bits = agsc_pkg::FRAME_BITS;
            next_timer = 16'(BIT_CYCLES - 1);
            next_busy = 1'b1;
        end
        else if (busy)
        begin
            if (timer != 16'h0000)
            begin
                next_timer = timer - 16'h0001;
            end
            else if (bits == 4'h1)
            begin
                next_busy = 1'b0;
                next_shift = {1'b1, shift[9:1]};
                next_bits = 4'h0;
            end
            else
            begin
                next_shift = {1'b1, shift[9:1]};
                next_bits = bits - 4'h1;
                next_timer = 16'(BIT_CYCLES - 1);
            end
        end
    end

    // line idles high between frames
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            shift <= 10'h3ff;
            bits <= 4'h0;
            timer <= 16'h0000;
            busy <= 1'b0;
        end
        else
        begin
            shift <= next_shift;
            bits <= next_bits;
            timer <= next_timer;
            busy <= next_busy;
        end
    end

    assign busy_o = busy;
    assign txd_o = shift[0];

endmodule
`default_nettype wire

// File: verilog/agsc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module agsc_ctrl #(
    parameter int unsigned BIT_CYCLES = agsc_pkg::BIT_CYCLES_DEF
)
(
    input wire logic CLK_I,
    input wire logic RST_B_I,
    input wire logic RESTART_I,
    input wire agsc_pkg::agsc_meas_type MEAS_I,
    input wire logic [5:0] PEAK_LIMIT_I,
    input wire agsc_pkg::agsc_man_type MAN_I,
    input wire logic UL_HIGH_I,
    input wire logic [3:0] FAIL_I,
    output logic [4:0] UL_ATTN_O,
    output logic [4:0] DL_ATTN_O,
    output logic SETUP_BUSY_O,
    output logic SETUP_DONE_O,
    output logic [3:0] ALARM_O,
    output logic MODEM_TXD_O
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [4:0] attn_up(input logic [4:0] a);
        attn_up = (a < agsc_pkg::ATTN_MAX) ? a + agsc_pkg::ATTN_STEP : a;
    endfunction

    function automatic logic [4:0] attn_clamp(input logic [4:0] a);
        attn_clamp = (a > agsc_pkg::ATTN_MAX) ? agsc_pkg::ATTN_MAX : a;
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers for pins
    // ----------------------------------------------------------------
    logic [4:0] sync1;
    logic [4:0] sync2;

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            sync1 <= 5'h00;
            sync2 <= 5'h00;
        end
        else
        begin
            sync1 <= {UL_HIGH_I, FAIL_I};
            sync2 <= sync1;
        end
    end

    // ----------------------------------------------------------------
    // gain control
    // ----------------------------------------------------------------
    agsc_pkg::agsc_state_type state;
    agsc_pkg::agsc_state_type next_state;
    logic [4:0] ul_attn;
    logic [4:0] next_ul_attn;
    logic [4:0] dl_attn;
    logic [4:0] next_dl_attn;
    logic [10:0] settle_cnt;
    logic [10:0] next_settle_cnt;
    logic done;
    logic next_done;
    logic busy;
    logic next_busy;
    logic ready;
    logic over;
    logic reached;
    logic man_wr;
    logic ul_high;

    assign ready = (settle_cnt == 11'h000) && MEAS_I.valid;
    assign over = MEAS_I.dbm > PEAK_LIMIT_I;
    assign reached = MEAS_I.dbm >= PEAK_LIMIT_I;
    assign man_wr = MAN_I.ul_wr | MAN_I.dl_wr;
    assign ul_high = sync2[4];

    // restart beats manual, manual beats the sequence
    always_comb
    begin
        next_state = state;
        next_ul_attn = ul_attn;
        next_dl_attn = dl_attn;
        next_settle_cnt = settle_cnt;
        if (settle_cnt != 11'h000)
        begin
            next_settle_cnt = settle_cnt - 11'h001;
        end
        next_done = 1'b0;
        case (state)
            agsc_pkg::ST_MAX:
            begin
                next_ul_attn = agsc_pkg::ATTN_MAX;
                next_dl_attn = agsc_pkg::ATTN_MAX;
                next_settle_cnt = agsc_pkg::SETTLE_CYC;
                next_state = agsc_pkg::ST_SETTLE;
            end
            agsc_pkg::ST_SETTLE:
            begin
                if (ready)
                begin
                    if (reached || dl_attn == agsc_pkg::ATTN_MIN)
                    begin
                        next_state = agsc_pkg::ST_DONE;
                    end
                    else
                    begin
                        // both paths move together to stay balanced
                        next_ul_attn = dl_attn - agsc_pkg::ATTN_STEP;
                        next_dl_attn = dl_attn - agsc_pkg::ATTN_STEP;
                        next_settle_cnt = agsc_pkg::SETTLE_CYC;
                    end
                end
            end
            agsc_pkg::ST_DONE:
            begin
                next_done = 1'b1;
                next_state = agsc_pkg::ST_TRACK;
            end
            agsc_pkg::ST_TRACK:
            begin
                // only ever adds; a falling level is ignored so the
                // base station power control is not fought
                if (ready && (over || ul_high))
                begin
                    if (over)
                    begin
                        next_dl_attn = attn_up(dl_attn);
                    end
                    next_ul_attn = attn_up(ul_attn);
                    next_settle_cnt = agsc_pkg::SETTLE_CYC;
                end
            end
            default:
            begin
                next_state = agsc_pkg::ST_MAX;
            end
        endcase
        if (man_wr)
        begin
            // manual values may sit outside the detector range
            if (MAN_I.ul_wr)
            begin
                next_ul_attn = attn_clamp(MAN_I.value);
            end
            if (MAN_I.dl_wr)
            begin
                next_dl_attn = attn_clamp(MAN_I.value);
            end
            next_settle_cnt = agsc_pkg::SETTLE_CYC;
            next_state = agsc_pkg::ST_TRACK;
            next_done = 1'b0;
        end
        if (RESTART_I)
        begin
            next_ul_attn = agsc_pkg::ATTN_MAX;
            next_dl_attn = agsc_pkg::ATTN_MAX;
            next_settle_cnt = agsc_pkg::SETTLE_CYC;
            next_state = agsc_pkg::ST_SETTLE;
            next_done = 1'b0;
        end
        next_busy = (next_state == agsc_pkg::ST_MAX) ||
                    (next_state == agsc_pkg::ST_SETTLE);
    end

    // power-up runs the sequence as if restarted
    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            state <= agsc_pkg::ST_MAX;
            ul_attn <= agsc_pkg::ATTN_MAX;
            dl_attn <= agsc_pkg::ATTN_MAX;
            settle_cnt <= agsc_pkg::SETTLE_CYC;
            done <= 1'b0;
            busy <= 1'b1;
        end
        else
        begin
            state <= next_state;
            ul_attn <= next_ul_attn;
            dl_attn <= next_dl_attn;
            settle_cnt <= next_settle_cnt;
            done <= next_done;
            busy <= next_busy;
        end
    end

    // ----------------------------------------------------------------
    // alarms and modem reports
    // ----------------------------------------------------------------
    logic [3:0] alarm;
    logic [3:0] next_alarm;
    logic [4:0] pend;
    logic [4:0] next_pend;
    logic [3:0] rise;
    logic tx_start;
    logic next_tx_start;
    logic [7:0] tx_byte;
    logic [7:0] next_tx_byte;
    logic tx_busy;

    assign rise = sync2[3:0] & ~alarm;

    // lowest pending wins; done report sits at bit 4
    always_comb
    begin
        next_alarm = sync2[3:0];
        next_pend = pend;
        next_tx_start = 1'b0;
        next_tx_byte = tx_byte;
        if (!tx_busy && !tx_start && pend != agsc_pkg::PEND_RST)
        begin
            next_tx_start = 1'b1;
            next_tx_byte = agsc_pkg::MSG_DONE;
            for (int i = agsc_pkg::N_ALARM - 1; i >= 0; i--)
            begin
                if (pend[i])
                begin
                    next_tx_byte = agsc_pkg::MSG_ALARM | 8'(i);
                end
            end
            for (int i = 0; i <= agsc_pkg::N_ALARM; i++)
            begin
                if (pend[i] && (pend & ((5'h01 << i) - 5'h01)) == 5'h00)
                begin
                    next_pend[i] = 1'b0;
                end
            end
        end
        // a new event beats the clear of its pending bit
        next_pend = next_pend | {done, rise};
    end

    always_ff @(posedge CLK_I or negedge RST_B_I)
    begin
        if (!RST_B_I)
        begin
            alarm <= agsc_pkg::ALARM_RST;
            pend <= agsc_pkg::PEND_RST;
            tx_start <= 1'b0;
            tx_byte <= 8'h00;
        end
        else
        begin
            alarm <= next_alarm;
            pend <= next_pend;
            tx_start <= next_tx_start;
            tx_byte <= next_tx_byte;
        end
    end

    agsc_modem_tx #(
        .BIT_CYCLES(BIT_CYCLES)
    ) u_modem_tx (
        .clk_i(CLK_I),
        .rst_b_i(RST_B_I),
        .start_i(tx_start),
        .byte_i(tx_byte),
        .busy_o(tx_busy),
        .txd_o(MODEM_TXD_O)
    );

    assign UL_ATTN_O = ul_attn;
    assign DL_ATTN_O = dl_attn;
    assign SETUP_BUSY_O = busy;
    assign SETUP_DONE_O = done;
    assign ALARM_O = alarm;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    AST_RESTART_MAX: assert property (
        RESTART_I |=> ul_attn == 5'h1e && dl_attn == 5'h1e && busy)
        else $error("restart did not force maximum attenuation");
    AST_STEP_ONE: assert property (
        state == agsc_pkg::ST_SETTLE && ready && !reached &&
        dl_attn != 5'h00 && !RESTART_I && !man_wr
        |=> dl_attn == $past(dl_attn) - 5'h01)
        else $error("setup step was not one dB down");
    AST_STOP_PEAK: assert property (
        state == agsc_pkg::ST_SETTLE && ready && reached &&
        !RESTART_I && !man_wr
        |=> $stable(dl_attn) ##1 done)
        else $error("setup did not stop at peak");
    AST_STOP_ZERO: assert property (
        state == agsc_pkg::ST_SETTLE && ready && dl_attn == 5'h00 &&
        !RESTART_I && !man_wr |=> dl_attn == 5'h00 && !busy)
        else $error("setup did not stop at zero attenuation");
    AST_ADD_OVER: assert property (
        state == agsc_pkg::ST_TRACK && ready && over &&
        dl_attn < 5'h1e && !RESTART_I && !man_wr
        |=> dl_attn == $past(dl_attn) + 5'h01)
        else $error("overdrive did not add attenuation");
    AST_NEVER_REMOVE: assert property (
        state == agsc_pkg::ST_TRACK && !RESTART_I && !man_wr
        |=> dl_attn >= $past(dl_attn) && ul_attn >= $past(ul_attn))
        else $error("attenuation removed after setup");
    AST_BALANCED: assert property (
        state == agsc_pkg::ST_SETTLE |-> ul_attn == dl_attn)
        else $error("uplink and downlink differ during setup");
    AST_ALARM_PEND: assert property (
        rise != 4'h0 && !tx_busy && !tx_start
        |=> (pend[3:0] & $past(rise)) == $past(rise)
        ##[1:3] tx_start)
        else $error("failure was not queued for the modem");
    AST_MANUAL: assert property (
        MAN_I.dl_wr && !RESTART_I && MAN_I.value <= 5'h1e
        |=> dl_attn == $past(MAN_I.value) && !busy)
        else $error("manual attenuation not applied");
    AST_SETTLED: assert property (
        settle_cnt != 11'h000 && !RESTART_I && !man_wr
        |=> $stable(dl_attn) && $stable(ul_attn))
        else $error("attenuation moved before settling");
    AST_DONE_PULSE: assert property (
        done |-> $past(state == agsc_pkg::ST_DONE) ##1 !done)
        else $error("completion not a single pulse");

endmodule
`default_nettype wire

// File: test/agsc_sensor_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// downlink power sensor and step attenuator path
// ----------------------------------------------------------------
module agsc_sensor_model #(
    parameter int unsigned PERIOD = 100
)
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [4:0] dl_attn_i,
    input wire logic [5:0] donor_i,
    output agsc_pkg::agsc_meas_type meas_o
);
    int unsigned count;
    logic [6:0] level;

    // output level rises 1 dB for each dB of attenuation removed
    always_comb
    begin
        level = 7'(donor_i) + 7'h1e - 7'(dl_attn_i);
        if (level > 7'h3f)
        begin
            level = 7'h3f;
        end
    end

    // one reading per period; dbm churns between readings so that a
    // stale value is never mistaken for a fresh one
    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            count <= 0;
            meas_o <= '0;
        end
        else if (count == PERIOD - 1)
        begin
            count <= 0;
            meas_o <= {1'b1, level[5:0]};
        end
        else
        begin
            count <= count + 1;
            meas_o <= {1'b0, ~meas_o.dbm};
        end
    end
endmodule
`default_nettype wire

// File: test/agsc_ctrl_bench.sv
`timescale 1ns/100ps
`default_nettype none
module agsc_ctrl_bench;
    localparam int unsigned BITS = 8;
    logic clk;
    logic rst_b;
    logic restart;
    logic ul_high;
    logic [3:0] fail;
    logic [5:0] peak;
    logic [5:0] donor;
    agsc_pkg::agsc_man_type man;
    agsc_pkg::agsc_meas_type meas;
    logic [4:0] ul_attn;
    logic [4:0] dl_attn;
    logic busy;
    logic done;
    logic [3:0] alarm;
    logic txd;
    logic [7:0] rx_byte;
    logic [7:0] rx_q[$];
    int fail_count = 0;
    int comparisons = 0;

    // ----------------------------------------------------------------
    // clock, design and far side
    // ----------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    agsc_ctrl #(.BIT_CYCLES(BITS)) dut (
        .CLK_I(clk), .RST_B_I(rst_b), .RESTART_I(restart),
        .MEAS_I(meas), .PEAK_LIMIT_I(peak), .MAN_I(man),
        .UL_HIGH_I(ul_high), .FAIL_I(fail), .UL_ATTN_O(ul_attn),
        .DL_ATTN_O(dl_attn), .SETUP_BUSY_O(busy), .SETUP_DONE_O(done),
        .ALARM_O(alarm), .MODEM_TXD_O(txd));

    agsc_sensor_model #(.PERIOD(100)) sensor (
        .clk_i(clk), .rst_b_i(rst_b), .dl_attn_i(dl_attn),
        .donor_i(donor), .meas_o(meas));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h",
                $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // bounded wait: 0 done pulse, 1 downlink, 2 uplink, 3 modem byte
    task automatic wait_for(input int sel, input logic [7:0] v,
        input int bound);
        int n;
        logic hit;
        n = 0;
        hit = 1'b0;
        while (!hit)
        begin
            @(negedge clk);
            case (sel)
                0: hit = (done === 1'b1);
                1: hit = (dl_attn === v[4:0]);
                2: hit = (ul_attn === v[4:0]);
                default: hit = (rx_q.size() > 0);
            endcase
            n++;
            if (!hit && n > bound)
            begin
                fail_count++;
                $display("CHECK FAILED at %0t: timeout got %h expected %h",
                    $time, 8'h00, v);
                give_verdict();
            end
        end
    endtask

    // modem decoder, sampling each bit at its centre
    initial
    begin
        forever
        begin
            @(negedge txd);
            repeat (BITS / 2) @(posedge clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BITS) @(posedge clk);
                rx_byte[i] = txd;
            end
            repeat (BITS) @(posedge clk);
            check({7'h00, txd}, 8'h01);
            rx_q.push_back(rx_byte);
        end
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic sc_reset();
        check(ul_attn, 8'h1e);
        check(dl_attn, 8'h1e);
        check(busy, 8'h01);
        check(txd, 8'h01);
    endtask

    // donor 20, peak 30: level reaches peak with 20 dB left in
    task automatic sc_setup_peak();
        rx_q.delete();
        wait_for(1, 8'h1d, 3000);
        check(ul_attn, 8'h1d);
        repeat (1200) @(negedge clk);
        check(dl_attn, 8'h1d);
        check(busy, 8'h01);
        wait_for(0, 8'h01, 20000);
        check(dl_attn, 8'h14);
        check(ul_attn, 8'h14);
        check(busy, 8'h00);
        @(negedge clk);
        check(done, 8'h00);
        wait_for(3, 8'h40, 400);
        check(rx_q.pop_front(), 8'h40);
    endtask

    // donor up then down; uplink too high adds uplink steps only
    task automatic sc_track();
        donor = 6'h17;
        wait_for(1, 8'h17, 8000);
        check(ul_attn, 8'h17);
        repeat (3000) @(negedge clk);
        check(dl_attn, 8'h17);
        donor = 6'h0a;
        repeat (3000) @(negedge clk);
        check(dl_attn, 8'h17);
        check(ul_attn, 8'h17);
        ul_high = 1'b1;
        wait_for(2, 8'h18, 3000);
        check(dl_attn, 8'h17);
        ul_high = 1'b0;
    endtask

    task automatic sc_manual();
        man = {1'b1, 1'b0, 5'h05};
        @(negedge clk);
        man = '0;
        @(negedge clk);
        check(ul_attn, 8'h05);
        check(dl_attn, 8'h17);
        man = {1'b0, 1'b1, 5'h19};
        @(negedge clk);
        man = '0;
        @(negedge clk);
        check(dl_attn, 8'h19);
        check(ul_attn, 8'h05);
    endtask

    // restart with no donor signal: setup runs out of attenuation
    task automatic sc_restart_zero();
        donor = 6'h00;
        peak = 6'h28; // limit kept inside 18 to rating plus one
        rx_q.delete();
        restart = 1'b1;
        @(negedge clk);
        restart = 1'b0;
        @(negedge clk);
        check(ul_attn, 8'h1e);
        check(dl_attn, 8'h1e);
        check(busy, 8'h01);
        wait_for(0, 8'h01, 50000);
        check(dl_attn, 8'h00);
        check(ul_attn, 8'h00);
        wait_for(3, 8'h40, 400);
        check(rx_q.pop_front(), 8'h40);
    endtask

    task automatic sc_alarm();
        rx_q.delete();
        fail = 4'h4;
        repeat (4) @(negedge clk);
        check({4'h0, alarm}, 8'h04);
        wait_for(3, 8'h82, 400);
        check(rx_q.pop_front(), 8'h82);
        fail = 4'h0;
        repeat (4) @(negedge clk);
        check({4'h0, alarm}, 8'h00);
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_b = 1'b0;
        restart = 1'b0;
        ul_high = 1'b0;
        fail = 4'h0;
        man = '0;
        peak = 6'h1e; // limit kept inside 18 to rating plus one
        donor = 6'h14;
        repeat (2) @(negedge clk);
        sc_reset();
        rst_b = 1'b1;
        sc_setup_peak();
        sc_track();
        sc_manual();
        sc_restart_zero();
        sc_alarm();
        give_verdict();
    end
endmodule
`default_nettype wire
